// ### naf_adc_model.sv
// converter sample stream model that feeds the filter
`timescale 1ns/1ps
`default_nettype none
module naf_adc_model
    import naf_pkg::*;
#(
    parameter int GAP = 4
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [SAMPLE_W-1:0] level,
    output naf_sample_t              adc_sample
);
    int cnt;
    // fixed-rate sample stream
    // the rate is compressed to one sample per GAP cycles so runs stay short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt        <= 0;
            adc_sample <= '0;
        end else begin
            cnt              <= (cnt == GAP - 1) ? 0 : cnt + 1;
            adc_sample.valid <= (cnt == GAP - 1);
            // between samples the data is inverted, so a stale capture shows up
            adc_sample.data  <= (cnt == GAP - 1) ? level : ~level;
        end
    end
endmodule
`default_nettype wire

// ### naf_filter.sv
// notch averaging filter: apb registers, measurement sequencer, boxcar averager
`timescale 1ns/1ps
`default_nettype none
module naf_filter
    import naf_pkg::*;
#(
    parameter int unsigned SETTLE_US_DEFAULT = SETTLE_US_DEF
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire naf_sample_t       adc_sample,
    output logic                   result_valid,
    output logic [SAMPLE_W-1:0]    result_data,
    output logic                   meas_busy
);
    // rounded sample count: (2*rate/f + 1)/2
    function automatic logic [CNT_W-1:0] naf_count(input logic [15:0] f);
        logic [31:0] q;
        q = 32'h0;
        if (f != 16'h0) begin
            q = ((32'(SAMPLE_RATE_HZ) * 32'h2) / 32'(f) + 32'h1) >> 1;
        end
        if (q == 32'h0) begin
            q = 32'h1;
        end
        return q[CNT_W-1:0];
    endfunction

    function automatic logic [31:0] naf_us_to_cyc(input logic [15:0] us);
        return 32'(us) * 32'(CYC_PER_US);
    endfunction

    naf_state_t             state_reg;
    logic [15:0]            notch_reg;
    logic [15:0]            settle_reg;
    logic                   bridge_reg;
    logic                   done_reg;
    logic                   start_pulse;
    logic [CNT_W-1:0]       ncount_reg;
    logic [ACC_W-1:0]       acc_reg;
    logic [CNT_W-1:0]       samp_cnt_reg;
    logic [31:0]            timer_reg;
    logic [1:0]             sub_reg;
    logic [31:0]            settle_cyc;
    logic                   apb_wr;
    logic                   apb_rd;
    logic                   last_sample;

    assign apb_wr = psel && penable && pwrite && pready;
    assign apb_rd = psel && !penable && !pwrite;
    assign start_pulse = apb_wr && (paddr == OFS_CTRL) && pwdata[CTRL_START_BIT]
                         && (state_reg == NAF_IDLE);
    // last sample of the averaging window
    assign last_sample = (state_reg == NAF_FILTER) && adc_sample.valid
                         && (samp_cnt_reg + 16'h1 == ncount_reg);

    // settle zero picks default
    assign settle_cyc = (settle_reg == 16'h0) ? naf_us_to_cyc(16'(SETTLE_US_DEFAULT))
                                              : naf_us_to_cyc(settle_reg);

    // one-cycle apb answer: pready rises in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            notch_reg  <= NOTCH_RST;
            settle_reg <= 16'h0;
            bridge_reg <= 1'b0;
        end else if (apb_wr) begin
            case (paddr)
                OFS_CTRL: begin
                    // a mode change mid-run would alter the sub-measurement count
                    if (state_reg == NAF_IDLE) begin
                        bridge_reg <= pwdata[CTRL_BRIDGE_BIT];
                    end
                end
                OFS_NOTCH:  notch_reg  <= pwdata[15:0];
                OFS_SETTLE: settle_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // error flag is only meaningful with pready; it may linger between transfers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (apb_rd) begin
            pslverr <= 1'b0;
            case (paddr)
                OFS_CTRL:   prdata <= {30'h0, bridge_reg, 1'b0};
                OFS_NOTCH:  prdata <= {16'h0, notch_reg};
                OFS_SETTLE: prdata <= {16'h0, settle_reg};
                OFS_STATUS: prdata <= {26'h0, sub_reg, 2'h0, done_reg,
                                       state_reg != NAF_IDLE};
                OFS_RESULT: prdata <= {{(32-SAMPLE_W){result_data[SAMPLE_W-1]}}, result_data};
                OFS_NCOUNT: prdata <= {{(32-CNT_W){1'b0}}, ncount_reg};
                default: begin
                    prdata  <= 32'h0;
                    pslverr <= 1'b1;
                end
            endcase
        end else if (psel && !penable) begin
            // unmapped address check also covers writes
            pslverr <= !(paddr inside {OFS_CTRL, OFS_NOTCH, OFS_SETTLE,
                                       OFS_STATUS, OFS_RESULT, OFS_NCOUNT});
        end
    end

    // R6 settle filter overhead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= NAF_IDLE;
            timer_reg  <= 32'h0;
            sub_reg    <= 2'h0;
            ncount_reg <= 16'h0;
        end else begin
            case (state_reg)
                NAF_IDLE: begin
                    if (start_pulse) begin
                        // R2 R3 rounded count
                        ncount_reg <= naf_count(notch_reg);
                        sub_reg    <= 2'h0;
                        timer_reg  <= 32'h0;
                        state_reg  <= NAF_SETTLE;
                    end
                end
                NAF_SETTLE: begin
                    // R7 settling interval
                    if (timer_reg + 32'h1 >= settle_cyc) begin
                        timer_reg <= 32'h0;
                        state_reg <= NAF_FILTER;
                    end else begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
                NAF_FILTER: begin
                    // R5 one notch period
                    if (last_sample) begin
                        state_reg <= NAF_OVERHEAD;
                    end
                end
                NAF_OVERHEAD: begin
                    if (timer_reg + 32'h1 >= 32'(OVERHEAD_CYC)) begin
                        timer_reg <= 32'h0;
                        // R8 four sub-measurements
                        if (bridge_reg && 32'(sub_reg) < SUBMEAS_BRIDGE - 1) begin
                            sub_reg   <= sub_reg + 2'h1;
                            state_reg <= NAF_SETTLE;
                        end else begin
                            state_reg <= NAF_IDLE;
                        end
                    end else begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
                default: state_reg <= NAF_IDLE;
            endcase
        end
    end

    // R1 R4 boxcar accumulate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg      <= '0;
            samp_cnt_reg <= '0;
        end else if (state_reg == NAF_SETTLE) begin
            // R9 clear per result
            acc_reg      <= '0;
            samp_cnt_reg <= '0;
        end else if (state_reg == NAF_FILTER && adc_sample.valid) begin
            acc_reg      <= acc_reg + ACC_W'($signed(adc_sample.data));
            samp_cnt_reg <= samp_cnt_reg + 16'h1;
        end
    end

    logic [ACC_W-1:0] acc_fin;
    logic [ACC_W-1:0] mean_full;
    assign acc_fin   = acc_reg + ACC_W'($signed(adc_sample.data));
    // divider is combinational; acceptable at the slow result rate
    assign mean_full = ACC_W'($signed(acc_fin) / $signed({1'b0, ncount_reg}));

    // R2 mean output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_valid <= 1'b0;
            result_data  <= '0;
            done_reg     <= 1'b0;
            meas_busy    <= 1'b0;
        end else begin
            meas_busy    <= (state_reg != NAF_IDLE) || start_pulse;
            result_valid <= 1'b0;
            if (last_sample) begin
                result_valid <= 1'b1;
                result_data  <= mean_full[SAMPLE_W-1:0];
                done_reg     <= 1'b1;
            end else if (start_pulse) begin
                done_reg <= 1'b0;
            end
        end
    end

    property p_count_50;
        @(posedge pclk) disable iff (!presetn)
        (start_pulse && notch_reg == 16'h0032) |=> (ncount_reg == 16'h0271);
    endproperty
    a_count_50: assert property (p_count_50) else $error("count for 50 Hz not 625"); // R2

    property p_count_60;
        @(posedge pclk) disable iff (!presetn)
        (start_pulse && notch_reg == 16'h003c) |=> (ncount_reg == 16'h0209);
    endproperty
    a_count_60: assert property (p_count_60) else $error("count for 60 Hz not 521"); // R3

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == NAF_SETTLE) |=> (samp_cnt_reg == 16'h0 && acc_reg == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("accumulator not cleared"); // R9

    property p_order;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == NAF_FILTER && $past(state_reg) != NAF_FILTER)
        |-> $past(state_reg) == NAF_SETTLE;
    endproperty
    a_order: assert property (p_order) else $error("filter not after settle"); // R6

    property p_result_end;
        @(posedge pclk) disable iff (!presetn)
        result_valid |-> state_reg == NAF_OVERHEAD && samp_cnt_reg == ncount_reg;
    endproperty
    a_result_end: assert property (p_result_end) else $error("result without full count"); // R5

    property p_default_settle;
        @(posedge pclk) disable iff (!presetn)
        (settle_reg == 16'h0) |-> settle_cyc == 32'(SETTLE_US_DEFAULT) * 32'(CYC_PER_US);
    endproperty
    a_default_settle: assert property (p_default_settle) else $error("bad default settle"); // R7

    property p_bridge_four;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == NAF_OVERHEAD && $past(state_reg) == NAF_OVERHEAD && !bridge_reg)
        |-> sub_reg == 2'h0;
    endproperty
    a_bridge_four: assert property (p_bridge_four) else $error("sub step without bridge"); // R8

    property p_samples_only_filter;
        @(posedge pclk) disable iff (!presetn)
        (samp_cnt_reg != $past(samp_cnt_reg) && samp_cnt_reg != 16'h0)
        |-> $past(state_reg) == NAF_FILTER && $past(adc_sample.valid);
    endproperty
    a_samples_only_filter: assert property (p_samples_only_filter) else $error("stray sample"); // R1

    property p_samp_bound;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == NAF_FILTER) |-> samp_cnt_reg < ncount_reg;
    endproperty
    a_samp_bound: assert property (p_samp_bound) else $error("count past window"); // R5

    property p_overhead_after;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == NAF_OVERHEAD && $past(state_reg) != NAF_OVERHEAD)
        |-> $past(state_reg) == NAF_FILTER;
    endproperty
    a_overhead_after: assert property (p_overhead_after) else $error("overhead early"); // R6

    property p_busy_track;
        @(posedge pclk) disable iff (!presetn)
        (state_reg != NAF_IDLE) |=> meas_busy;
    endproperty
    a_busy_track: assert property (p_busy_track) else $error("busy low during run"); // R6

    property p_bridge_resettle;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == NAF_SETTLE && $past(state_reg) == NAF_OVERHEAD)
        |-> bridge_reg && sub_reg != 2'h0;
    endproperty
    a_bridge_resettle: assert property (p_bridge_resettle) else $error("stray resettle"); // R8

    // scenario coverage
    c_result: cover property (@(posedge pclk) disable iff (!presetn) result_valid);
    c_bridge: cover property (@(posedge pclk) disable iff (!presetn) sub_reg == 2'h3);
    c_settle_set: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == NAF_SETTLE && settle_reg != 16'h0);
    c_notch_60: cover property (@(posedge pclk) disable iff (!presetn)
        start_pulse && notch_reg == 16'h003c);
    c_bus_error: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule
`default_nettype wire

// ### naf_pkg.sv
// package: constants, types and register map of the notch averaging filter
// Overview of operation
// R1 - converter samples arrive at a fixed 31250 per second; every result uses them.
// R2 - each result is the mean of N samples, N = 31250 / notch frequency.
// R3 - a fractional sample count is rounded to the nearest integer, e.g. 521 at 60 Hz.
// R4 - the boxcar over one period nulls the notch frequency and its multiples.
// R5 - averaging lasts one notch period, 20 ms at 50 Hz.
// R6 - one result takes settling, then filtering, then fixed overhead, in that order.
// R7 - a zero settling setting selects the built-in default settling interval.
// R8 - a reversed bridge measurement applies settling in each of four sub-measurements.
// R9 - accumulator and sample counter clear at the start of every result.
package naf_pkg;
    localparam int unsigned CLK_HZ           = 125_000_000;
    localparam int unsigned SAMPLE_RATE_HZ   = 31250;
    localparam int unsigned SAMPLE_W         = 24;
    localparam int unsigned CNT_W            = 16;
    localparam int unsigned ACC_W            = SAMPLE_W + CNT_W;
    // settling setting in microseconds
    localparam int unsigned SETTLE_US_DEF    = 100;
    localparam int unsigned OVERHEAD_US      = 10;
    localparam int unsigned CYC_PER_US       = CLK_HZ / 1_000_000;
    localparam int unsigned OVERHEAD_CYC     = OVERHEAD_US * CYC_PER_US;
    localparam int unsigned SUBMEAS_BRIDGE   = 4;
    localparam logic [15:0] NOTCH_RST        = 16'h0032;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL          = 8'h00;
    localparam logic [7:0] OFS_NOTCH         = 8'h04;
    localparam logic [7:0] OFS_SETTLE        = 8'h08;
    localparam logic [7:0] OFS_STATUS        = 8'h0c;
    localparam logic [7:0] OFS_RESULT        = 8'h10;
    localparam logic [7:0] OFS_NCOUNT        = 8'h14;
    localparam int unsigned CTRL_START_BIT   = 0;
    localparam int unsigned CTRL_BRIDGE_BIT  = 1;
    localparam int unsigned STAT_BUSY_BIT    = 0;
    localparam int unsigned STAT_DONE_BIT    = 1;
    localparam int unsigned STAT_SUB_LSB     = 4;

    typedef enum logic [1:0] {
        NAF_IDLE,
        NAF_SETTLE,
        NAF_FILTER,
        NAF_OVERHEAD
    } naf_state_t;

    typedef struct packed {
        logic                  valid;
        logic [SAMPLE_W-1:0]   data;
    } naf_sample_t;
endpackage

// ### notch_averaging_filter_bench.sv
// self-checking bench of the notch averaging filter
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, x, g); end end
module notch_averaging_filter_bench
    import naf_pkg::*;
;
    localparam int GAP    = 4;
    localparam int DEF_US = 1;
    logic                pclk    = 1'b0;
    logic                presetn = 1'b0;
    logic                psel    = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite  = 1'b0;
    logic [7:0]          paddr   = '0;
    logic [31:0]         pwdata  = '0;
    logic [31:0]         prdata;
    logic [31:0]         q;
    logic                pready;
    logic                pslverr;
    logic                e;
    logic                result_valid;
    logic                meas_busy;
    logic [SAMPLE_W-1:0] result_data;
    logic [SAMPLE_W-1:0] r;
    logic [SAMPLE_W-1:0] level   = '0;
    naf_sample_t         adc_sample;
    int                  n_mismatch = 0;
    int                  cmp_count  = 0;

    always #4 pclk = ~pclk;

    naf_filter #(.SETTLE_US_DEFAULT(DEF_US)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_sample(adc_sample),
        .result_valid(result_valid), .result_data(result_data), .meas_busy(meas_busy));
    naf_adc_model #(.GAP(GAP)) adc (
        .pclk(pclk), .presetn(presetn), .level(level), .adc_sample(adc_sample));

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // entered just after a rising edge; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        `CHK("pready", 1'b1, pready)
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_res(output int c);
        c = 0;
        while (result_valid !== 1'b1 && c < 30000) begin
            @(posedge pclk);
            c++;
        end
        r = result_data;
        @(posedge pclk);
    endtask

    task automatic t_regs();
        apb(1'b0, OFS_NOTCH, '0);
        `CHK("notch_rst", 32'(NOTCH_RST), q)
        apb(1'b1, OFS_NOTCH, 32'hffff_003c);
        apb(1'b0, OFS_NOTCH, '0);
        `CHK("notch_wr", 32'h0000_003c, q)
        apb(1'b0, 8'h20, '0);
        `CHK("unmapped_err", 1'b1, e)
        `CHK("unmapped_rd", 32'h0, q)
        apb(1'b1, 8'h20, 32'hffff_ffff);
        `CHK("unmapped_wr_err", 1'b1, e)
    endtask

    task automatic t_run(input int notch, input int us, input int lv, input int nexp);
        int c;
        int t;
        int sc;
        sc = (us == 0 ? DEF_US : us) * CYC_PER_US;
        t = 0;
        level <= lv[SAMPLE_W-1:0];
        apb(1'b1, OFS_NOTCH, 32'(notch));
        apb(1'b1, OFS_SETTLE, 32'(us));
        apb(1'b1, OFS_CTRL, 32'h1);
        `CHK("busy", 1'b1, meas_busy)
        wait_res(c);
        `CHK("t_res", 1'b1, c >= sc + (nexp - 1) * GAP - 3 && c <= sc + (nexp + 2) * GAP)
        `CHK("result", lv[SAMPLE_W-1:0], r)
        while (meas_busy === 1'b1 && t < 5000) begin
            @(posedge pclk);
            t++;
        end
        `CHK("t_ovh", 1'b1, t >= OVERHEAD_CYC - 2 && t <= OVERHEAD_CYC + 3)
        apb(1'b0, OFS_NCOUNT, '0);
        `CHK("ncount", 32'(nexp), q)
    endtask

    task automatic t_bridge();
        int c;
        int k;
        c = 0;
        k = 0;
        level <= 24'h000123;
        apb(1'b1, OFS_NOTCH, 32'd50);
        apb(1'b1, OFS_SETTLE, 32'd0);
        apb(1'b1, OFS_CTRL, 32'h3);
        // a second start while busy must not add sub-measurements
        apb(1'b1, OFS_CTRL, 32'h3);
        while (meas_busy === 1'b1 && c < 60000) begin
            if (result_valid === 1'b1) begin
                k++;
                `CHK("b_res", 24'h000123, result_data)
            end
            @(posedge pclk);
            c++;
        end
        `CHK("b_count", SUBMEAS_BRIDGE, k)
        `CHK("b_end", 1'b1, c < 60000)
        apb(1'b0, OFS_STATUS, '0);
        `CHK("b_status", 32'h0000_0032, q)
        apb(1'b0, OFS_CTRL, '0);
        `CHK("b_mode", 32'h0000_0002, q)
        `CHK("b_time", 1'b1, c > 4 * (DEF_US * CYC_PER_US + 624 * GAP) + 3 * OVERHEAD_CYC)
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_run(50, 0, -1000, 625);
        t_run(60, 20, 12345, 521);
        t_run(1000, 0, 7, 31);
        t_bridge();
        finish_test();
    end

    initial begin
        #(8 * 80000);
        n_mismatch++;
        finish_test();
    end
endmodule
`default_nettype wire
